// ===== rtl/limit_alert_pkg.sv
// Constants and types shared by the telemetry limit-alert unit.
// Assumes a 100 MHz core clock and a command-code register port.
package limit_alert_pkg;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_BATTERY_VOLTAGE_LOW_LIMIT  = 8'h01;
    localparam logic [7:0] CMD_BATTERY_VOLTAGE_HIGH_LIMIT = 8'h02;
    localparam logic [7:0] CMD_INPUT_VOLTAGE_LOW_LIMIT    = 8'h03;
    localparam logic [7:0] CMD_INPUT_VOLTAGE_HIGH_LIMIT   = 8'h04;
    localparam logic [7:0] CMD_OUTPUT_VOLTAGE_LOW_LIMIT   = 8'h05;
    localparam logic [7:0] CMD_OUTPUT_VOLTAGE_HIGH_LIMIT  = 8'h06;
    localparam logic [7:0] CMD_INPUT_CURRENT_HIGH_LIMIT   = 8'h07;
    localparam logic [7:0] CMD_BATTERY_CURRENT_LOW_LIMIT  = 8'h08;
    localparam logic [7:0] CMD_DIE_TEMPERATURE_HIGH_LIMIT = 8'h09;
    localparam logic [7:0] CMD_BATTERY_RESISTANCE_HIGH_LIMIT = 8'h0A;
    localparam logic [7:0] CMD_NTC_VOLTAGE_HIGH_LIMIT     = 8'h0B;
    localparam logic [7:0] CMD_NTC_VOLTAGE_LOW_LIMIT      = 8'h0C;
    localparam logic [7:0] CMD_LIMIT_ALERT_ENABLES        = 8'h0D;
    localparam int         LIMIT_FIRST                    = 1;
    localparam int         LIMIT_LAST                     = 12;

    // ------------------------------------------------------------
    // Reset values and enable bit positions
    // ------------------------------------------------------------
    localparam logic [15:0] LIMIT_RESET          = 16'h0000;
    localparam logic [15:0] ENABLES_RESET        = 16'h0000;
    localparam logic [15:0] ENABLES_WRITABLE     = 16'hCFFF;
    localparam int          BIT_TELEMETRY_VALID  = 15;
    localparam int          BIT_RESISTANCE_DONE  = 14;
    localparam int          LIMIT_FLAG_COUNT     = 12;

    // ------------------------------------------------------------
    // Warm-up timing
    // ------------------------------------------------------------
    localparam int CLK_FREQ_HZ       = 100_000_000;
    localparam int WARMUP_TIME_MS    = 12;
    localparam int WARMUP_CYCLES     = WARMUP_TIME_MS * (CLK_FREQ_HZ / 1000);
    localparam int WARMUP_CNT_WIDTH  = 21;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CH_BATTERY_VOLTAGE,
        CH_INPUT_VOLTAGE,
        CH_OUTPUT_VOLTAGE,
        CH_INPUT_CURRENT,
        CH_BATTERY_CURRENT,
        CH_DIE_TEMPERATURE,
        CH_BATTERY_RESISTANCE,
        CH_NTC_VOLTAGE
    } meas_chan_e;

    typedef struct packed {
        logic        valid;
        meas_chan_e  chan;
        logic [15:0] value;
    } meas_result_s;

    typedef struct packed {
        logic [7:0]  addr;
        logic        write;
        logic [15:0] wdata;
    } reg_req_s;

    // Per flag bit 0..11: measured channel, limit command, compare sense
    localparam meas_chan_e FLAG_CHAN [LIMIT_FLAG_COUNT] = '{
        CH_NTC_VOLTAGE, CH_NTC_VOLTAGE, CH_BATTERY_RESISTANCE, CH_DIE_TEMPERATURE,
        CH_BATTERY_CURRENT, CH_INPUT_CURRENT, CH_OUTPUT_VOLTAGE, CH_OUTPUT_VOLTAGE,
        CH_INPUT_VOLTAGE, CH_INPUT_VOLTAGE, CH_BATTERY_VOLTAGE, CH_BATTERY_VOLTAGE};
    localparam logic [7:0] FLAG_LIMIT_CMD [LIMIT_FLAG_COUNT] = '{
        8'h0C, 8'h0B, 8'h0A, 8'h09, 8'h08, 8'h07, 8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01};
    localparam logic [11:0] FLAG_IS_HIGH = 12'h56E;

endpackage : limit_alert_pkg

// ===== rtl/sync_two_ff.sv
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the level is stable for several clock cycles.
module sync_two_ff
(
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic firstStage_reg;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            firstStage_reg <= 1'b0;
            syncOut        <= 1'b0;
        end
        else
        begin
            firstStage_reg <= asyncIn;
            syncOut        <= firstStage_reg;
        end
    end
endmodule : sync_two_ff

// ===== rtl/limit_compare.sv
// Signed two's-complement compare of one result against one limit.
// Assumes both operands are 16-bit two's complement.
module limit_compare #(
    parameter bit IS_HIGH = 1'b1
)
(
    input  wire logic [15:0] value,
    input  wire logic [15:0] limit,
    output logic             trip
);
    always_comb
    begin
        if (IS_HIGH)
            trip = $signed(value) > $signed(limit);
        else
            trip = $signed(value) < $signed(limit);
    end
endmodule : limit_compare

// ===== rtl/telemetry_limit_alert_unit.sv
// Limit registers, alert enables, latched alert flags and SMBus alert drive.
// Assumes an SMBus front end presents decoded command accesses on regReq,
// and the measurement engine presents one result per valid pulse.
//
// Summary of operation
// - Battery current low limit register, fires below.
// - Battery current compare works for either polarity.
// - Telemetry runs when input above battery, or forced.
// - Die temperature high limit register, fires above.
// - Battery resistance high limit register, fires above.
// - Thermistor high limit, flag readable, clearable, enabled.
// - Thermistor low limit, flag readable, clearable, enabled.
// - Alert enable register, resets to zero.
// - Bit 15 flags telemetry valid and alerts.
// - 12 ms warm-up; charger held off meanwhile.
// - Bit 14 flags resistance measurement done.
// - Bit 11 flags battery voltage below limit.
// - Bit 10 flags battery voltage above limit.
// - Flags stay latched until host clears them.
// - Bits 9..0 gate remaining limit alerts.
module telemetry_limit_alert_unit
    import limit_alert_pkg::*;
#(
    parameter int WARMUP_LENGTH = WARMUP_CYCLES
)
(
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire reg_req_s     regReq,
    output logic [15:0]       regRdata,
    input  wire meas_result_s measResult,
    input  wire logic         resistanceDone,
    input  wire logic         inputAboveBattery,
    input  wire logic         forceTelemetryOn,
    input  wire logic [15:0]  flagClear,
    output logic [15:0]       alertFlags,
    output logic              telemetryRunning,
    output logic              telemetryValid,
    output logic              chargerAllowed,
    input  wire logic         smbAlertIn,
    output logic              smbAlertOut,
    output logic              smbAlertOeN,
    output logic              alertLineLow
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic inputAboveBatterySync;

    sync_two_ff u_syncInputAbove
    (
        .clk     (clk),
        .reset   (reset),
        .asyncIn (inputAboveBattery),
        .syncOut (inputAboveBatterySync)
    );

    sync_two_ff u_syncAlertLine
    (
        .clk     (clk),
        .reset   (reset),
        .asyncIn (~smbAlertIn),
        .syncOut (alertLineLow)
    );

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [15:0] limit_reg [LIMIT_FIRST:LIMIT_LAST];
    logic [15:0] enables_reg;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            for (int i = LIMIT_FIRST; i <= LIMIT_LAST; i++)
                limit_reg[i] <= LIMIT_RESET;
        end
        else if (regReq.write)
        begin
            for (int i = LIMIT_FIRST; i <= LIMIT_LAST; i++)
                if (regReq.addr == 8'(i))
                    limit_reg[i] <= regReq.wdata;
        end
    end

    // Bits 13:12 have no condition behind them and read as zero
    always_ff @(posedge clk)
    begin
        if (reset)
            enables_reg <= ENABLES_RESET;
        else if (regReq.write && regReq.addr == CMD_LIMIT_ALERT_ENABLES)
            enables_reg <= regReq.wdata & ENABLES_WRITABLE;
    end

    // Read data registered, one cycle after the address
    always_ff @(posedge clk)
    begin
        if (reset)
            regRdata <= 16'h0000;
        else
        begin
            regRdata <= 16'h0000;
            if (regReq.addr == CMD_LIMIT_ALERT_ENABLES)
                regRdata <= enables_reg;
            for (int i = LIMIT_FIRST; i <= LIMIT_LAST; i++)
                if (regReq.addr == 8'(i))
                    regRdata <= limit_reg[i];
        end
    end

    // ------------------------------------------------------------
    // Telemetry run control and warm-up
    // ------------------------------------------------------------
    typedef enum logic [1:0] {TEL_OFF, TEL_WARMUP, TEL_VALID} tel_state_e;

    tel_state_e                  telState_reg;
    tel_state_e                  telState_next;
    logic [WARMUP_CNT_WIDTH-1:0] warmCount_reg;
    logic                        telemetryWanted;
    logic                        warmupDone;
    logic                        validRise;

    assign telemetryWanted = inputAboveBatterySync | forceTelemetryOn;
    assign warmupDone      = warmCount_reg == WARMUP_CNT_WIDTH'(WARMUP_LENGTH - 1);

    always_comb
    begin
        telState_next = telState_reg;
        case (telState_reg)
            TEL_OFF:
                if (telemetryWanted)
                    telState_next = TEL_WARMUP;
            TEL_WARMUP:
                if (!telemetryWanted)
                    telState_next = TEL_OFF;
                else if (warmupDone)
                    telState_next = TEL_VALID;
            TEL_VALID:
                if (!telemetryWanted)
                    telState_next = TEL_OFF;
            default:
                telState_next = TEL_OFF;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            telState_reg <= TEL_OFF;
        else
            telState_reg <= telState_next;
    end

    always_ff @(posedge clk)
    begin
        if (reset || telState_reg != TEL_WARMUP)
            warmCount_reg <= '0;
        else
            warmCount_reg <= warmCount_reg + 1'b1;
    end

    assign telemetryRunning = telState_reg != TEL_OFF;
    assign telemetryValid   = telState_reg == TEL_VALID;
    assign validRise        = telState_reg == TEL_WARMUP && telState_next == TEL_VALID;

    // Charger held off through warm-up regardless of the enables
    always_ff @(posedge clk)
    begin
        if (reset)
            chargerAllowed <= 1'b0;
        else
            chargerAllowed <= telState_next == TEL_VALID;
    end

    // ------------------------------------------------------------
    // Limit compares
    // ------------------------------------------------------------
    logic [LIMIT_FLAG_COUNT-1:0] trip;
    logic [LIMIT_FLAG_COUNT-1:0] limitHit;

    for (genvar k = 0; k < LIMIT_FLAG_COUNT; k++)
    begin : g_compare
        limit_compare #(
            .IS_HIGH (FLAG_IS_HIGH[k])
        ) u_compare
        (
            .value (measResult.value),
            .limit (limit_reg[int'(FLAG_LIMIT_CMD[k])]),
            .trip  (trip[k])
        );
        // Only fresh results from a warmed-up engine count
        assign limitHit[k] = measResult.valid && telemetryValid
                             && measResult.chan == FLAG_CHAN[k] && trip[k];
    end

    // ------------------------------------------------------------
    // Latched flags and alert line
    // ------------------------------------------------------------
    logic [15:0] flagSet;
    logic [15:0] alertFlags_next;

    always_comb
    begin
        flagSet                      = 16'h0000;
        flagSet[LIMIT_FLAG_COUNT-1:0] = limitHit & enables_reg[LIMIT_FLAG_COUNT-1:0];
        flagSet[BIT_RESISTANCE_DONE] = resistanceDone & enables_reg[BIT_RESISTANCE_DONE];
        flagSet[BIT_TELEMETRY_VALID] = validRise & enables_reg[BIT_TELEMETRY_VALID];
        // A set arriving with its clear wins
        alertFlags_next = (alertFlags & ~flagClear) | flagSet;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            alertFlags <= 16'h0000;
        else
            alertFlags <= alertFlags_next;
    end

    assign smbAlertOut = 1'b0;
    assign smbAlertOeN = ~|alertFlags;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_ENABLES_RESET: assert property (
        $past(reset) |-> enables_reg == 16'h0000)
        else $error("Enables not zero after reset");

    AST_IBAT_LOW_FIRES: assert property (
        measResult.valid && telemetryValid && measResult.chan == CH_BATTERY_CURRENT
        && $signed(measResult.value) < $signed(limit_reg[8]) && enables_reg[4]
        |=> alertFlags[4])
        else $error("Battery current low flag missed");

    AST_DIE_HIGH_FIRES: assert property (
        measResult.valid && telemetryValid && measResult.chan == CH_DIE_TEMPERATURE
        && $signed(measResult.value) > $signed(limit_reg[9]) && enables_reg[3]
        |=> alertFlags[3])
        else $error("Die temperature high flag missed");

    AST_NO_SET_WHEN_DISABLED: assert property (
        !enables_reg[2] && !alertFlags[2] |=> !alertFlags[2])
        else $error("Resistance high flag set while disabled");

    AST_FLAG_HOLDS: assert property (
        alertFlags[1] && !flagClear[1] |=> alertFlags[1])
        else $error("Thermistor high flag dropped without clear");

    AST_CLEAR_WORKS: assert property (
        flagClear[0] && !flagSet[0] |=> !alertFlags[0])
        else $error("Thermistor low flag not cleared");

    AST_BSR_DONE: assert property (
        resistanceDone && enables_reg[14] |=> alertFlags[14])
        else $error("Resistance done flag missed");

    AST_VALID_FLAG: assert property (
        $rose(telemetryValid) && $past(enables_reg[15]) |-> alertFlags[15])
        else $error("Telemetry valid flag missed");

    AST_CHARGER_HELD: assert property (
        telState_reg != TEL_VALID |-> !chargerAllowed)
        else $error("Charger allowed before warm-up end");

    AST_WARMUP_START: assert property (
        telState_reg == TEL_OFF && telemetryWanted |=> telState_reg == TEL_WARMUP)
        else $error("Telemetry did not start");

    AST_ALERT_LINE: assert property (
        !smbAlertOeN && flagClear == 16'h0000 |=> !smbAlertOeN && !smbAlertOut)
        else $error("Alert line released without a clear");

    AST_ALERT_RELEASE: assert property (
        flagClear == 16'hFFFF && flagSet == 16'h0000 |=> smbAlertOeN)
        else $error("Alert line held after all flags cleared");

    AST_VBAT_HIGH: assert property (
        measResult.valid && telemetryValid && measResult.chan == CH_BATTERY_VOLTAGE
        && $signed(measResult.value) > $signed(limit_reg[2]) && enables_reg[10]
        ##1 !flagClear[10] |-> alertFlags[10])
        else $error("Battery voltage high flag missed");

    AST_VBAT_LOW: assert property (
        measResult.valid && telemetryValid && measResult.chan == CH_BATTERY_VOLTAGE
        && $signed(measResult.value) < $signed(limit_reg[1]) && enables_reg[11]
        |=> alertFlags[11])
        else $error("Battery voltage low flag missed");

    AST_VIN_LOW: assert property (
        measResult.valid && telemetryValid && measResult.chan == CH_INPUT_VOLTAGE
        && $signed(measResult.value) < $signed(limit_reg[3]) && enables_reg[9]
        |=> alertFlags[9])
        else $error("Input voltage low flag missed");

    AST_VOUT_HIGH: assert property (
        measResult.valid && telemetryValid && measResult.chan == CH_OUTPUT_VOLTAGE
        && $signed(measResult.value) > $signed(limit_reg[6]) && enables_reg[6]
        |=> alertFlags[6])
        else $error("Output voltage high flag missed");

    AST_IIN_HIGH: assert property (
        measResult.valid && telemetryValid && measResult.chan == CH_INPUT_CURRENT
        && $signed(measResult.value) > $signed(limit_reg[7]) && enables_reg[5]
        |=> alertFlags[5])
        else $error("Input current high flag missed");

    AST_BSR_HIGH: assert property (
        measResult.valid && telemetryValid && measResult.chan == CH_BATTERY_RESISTANCE
        && $signed(measResult.value) > $signed(limit_reg[10]) && enables_reg[2]
        |=> alertFlags[2])
        else $error("Resistance high flag missed");

    AST_NTC_HIGH: assert property (
        measResult.valid && telemetryValid && measResult.chan == CH_NTC_VOLTAGE
        && $signed(measResult.value) > $signed(limit_reg[11]) && enables_reg[1]
        |=> alertFlags[1])
        else $error("Thermistor high flag missed");

    AST_NTC_LOW: assert property (
        measResult.valid && telemetryValid && measResult.chan == CH_NTC_VOLTAGE
        && $signed(measResult.value) < $signed(limit_reg[12]) && enables_reg[0]
        |=> alertFlags[0])
        else $error("Thermistor low flag missed");

    AST_SET_WINS: assert property (
        flagSet[4] && flagClear[4] |=> alertFlags[4])
        else $error("Clear beat a simultaneous set");

    AST_DISABLED_QUIET: assert property (
        enables_reg == 16'h0000 && alertFlags == 16'h0000 |=> alertFlags == 16'h0000)
        else $error("Flag set with all enables off");

    COVER_WARMUP_DONE: cover property (telState_reg == TEL_WARMUP ##1 telemetryValid);
    COVER_SET_AND_CLEAR: cover property (flagSet[4] && flagClear[4]);
    COVER_ALERT_RELEASE: cover property (!smbAlertOeN ##1 smbAlertOeN);
    COVER_LIMIT_TRIP: cover property (|limitHit);

endmodule : telemetry_limit_alert_unit

// ===== verif/smbus_alert_host.sv
// Host-side model of the open-drain alert wire with its pull-up.
// Assumes the device drives smbAlertOut while smbAlertOeN is low.
module smbus_alert_host
(
    input  wire logic smbAlertOut,
    input  wire logic smbAlertOeN,
    output logic      alertWire
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Wire level
    // ------------------------------------------------------------
    // Released wire floats up to the pull-up level
    assign alertWire = smbAlertOeN ? 1'b1 : smbAlertOut;

endmodule : smbus_alert_host

// ===== verif/telemetry_limit_alert_unit_test.sv
// Self-checking bench for the limit-alert unit.
// Assumes WARMUP_LENGTH of 8 cycles and the alert-wire host model.
module telemetry_limit_alert_unit_test
    import limit_alert_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic         clk;
    logic         reset;
    reg_req_s     regReq;
    meas_result_s measResult;
    logic         resistanceDone;
    logic         inputAboveBattery;
    logic         forceTelemetryOn;
    logic [15:0]  flagClear;
    logic [15:0]  regRdata;
    logic [15:0]  alertFlags;
    logic         telemetryRunning;
    logic         telemetryValid;
    logic         chargerAllowed;
    logic         smbAlertIn;
    logic         smbAlertOut;
    logic         smbAlertOeN;
    logic         alertLineLow;
    int           error_cnt;
    int           checked;

    // ------------------------------------------------------------
    // Stimulus tables
    // ------------------------------------------------------------
    localparam logic [7:0]  L_ADDR [7] = '{8'h01, 8'h02, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C};
    localparam logic [15:0] L_VAL [7] = '{16'h1000, 16'h2000, 16'hFF00, 16'h0100,
                                          16'h0200, 16'h3000, 16'h0800};
    localparam meas_chan_e T_CHAN [15] = '{CH_BATTERY_VOLTAGE, CH_BATTERY_VOLTAGE,
        CH_BATTERY_VOLTAGE, CH_INPUT_VOLTAGE, CH_INPUT_VOLTAGE, CH_OUTPUT_VOLTAGE,
        CH_OUTPUT_VOLTAGE, CH_INPUT_CURRENT, CH_BATTERY_CURRENT, CH_BATTERY_CURRENT,
        CH_DIE_TEMPERATURE, CH_DIE_TEMPERATURE, CH_BATTERY_RESISTANCE, CH_NTC_VOLTAGE,
        CH_NTC_VOLTAGE};
    localparam logic [15:0] T_VAL [15] = '{16'h0FFF, 16'h2001, 16'h2000, 16'hFFFF, 16'h0001,
        16'hFFFF, 16'h0001, 16'h0001, 16'hFE00, 16'h0010, 16'h8000, 16'h0101, 16'h0201,
        16'h3001, 16'h07FF};
    // Equal values and wrong-sign values must not trip
    localparam logic [15:0] T_EXP [15] = '{16'h0800, 16'h0400, 16'h0000, 16'h0200, 16'h0100,
        16'h0080, 16'h0040, 16'h0020, 16'h0010, 16'h0000, 16'h0000, 16'h0008, 16'h0004,
        16'h0002, 16'h0001};

    telemetry_limit_alert_unit #(
        .WARMUP_LENGTH (8)
    ) u_telemetry_limit_alert_unit (
        .clk               (clk),
        .reset             (reset),
        .regReq            (regReq),
        .regRdata          (regRdata),
        .measResult        (measResult),
        .resistanceDone    (resistanceDone),
        .inputAboveBattery (inputAboveBattery),
        .forceTelemetryOn  (forceTelemetryOn),
        .flagClear         (flagClear),
        .alertFlags        (alertFlags),
        .telemetryRunning  (telemetryRunning),
        .telemetryValid    (telemetryValid),
        .chargerAllowed    (chargerAllowed),
        .smbAlertIn        (smbAlertIn),
        .smbAlertOut       (smbAlertOut),
        .smbAlertOeN       (smbAlertOeN),
        .alertLineLow      (alertLineLow)
    );

    smbus_alert_host u_smbus_alert_host (
        .smbAlertOut (smbAlertOut),
        .smbAlertOeN (smbAlertOeN),
        .alertWire   (smbAlertIn)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        regReq <= '{addr: a, write: 1'b1, wdata: d};
        @(posedge clk);
        regReq.write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        regReq.addr <= a;
        @(posedge clk);
        #1 chk(regRdata, exp);
    endtask : rd

    task automatic meas(input meas_chan_e c, input logic [15:0] v, input logic [15:0] exp);
        @(posedge clk);
        measResult <= '{valid: 1'b1, chan: c, value: v};
        @(posedge clk);
        measResult.valid <= 1'b0;
        #1 chk(alertFlags, exp);
        chk({15'h0, smbAlertOeN}, {15'h0, exp == 16'h0000});
        chk({15'h0, smbAlertIn}, {15'h0, exp == 16'h0000});
    endtask : meas

    task automatic pulseDone(input logic [15:0] exp);
        @(posedge clk);
        resistanceDone <= 1'b1;
        @(posedge clk);
        resistanceDone <= 1'b0;
        #1 chk(alertFlags, exp);
    endtask : pulseDone

    task automatic clr();
        @(posedge clk);
        flagClear <= 16'hFFFF;
        @(posedge clk);
        flagClear <= 16'h0000;
        #1 chk(alertFlags, 16'h0000);
    endtask : clr

    task automatic waitValid();
        // Looked at mid-cycle, where the state register has settled
        for (int n = 0; n < 40 && telemetryValid !== 1'b1; n++)
            @(negedge clk);
        #1 chk({15'h0, telemetryValid}, 16'h0001);
    endtask : waitValid

    task automatic give_verdict();
        $display("Mismatches: %0d, comparisons: %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        error_cnt = 0;
        checked = 0;
        reset = 1'b1;
        regReq = '0;
        measResult = '0;
        resistanceDone = 1'b0;
        inputAboveBattery = 1'b0;
        forceTelemetryOn = 1'b0;
        flagClear = 16'h0000;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        for (int a = 1; a <= 13; a++)
            rd(8'(a), 16'h0000);
        rd(8'h20, 16'h0000);
        chk({15'h0, smbAlertOeN}, 16'h0001);
        wr(8'h0D, 16'hFFFF);
        rd(8'h0D, ENABLES_WRITABLE);
        for (int i = 0; i < 7; i++)
        begin
            wr(L_ADDR[i], L_VAL[i]);
            rd(L_ADDR[i], L_VAL[i]);
        end
        // Results before warm-up ends are ignored
        meas(CH_BATTERY_VOLTAGE, 16'h0FFF, 16'h0000);
        @(posedge clk);
        forceTelemetryOn <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk({15'h0, telemetryRunning}, 16'h0001);
        chk({15'h0, chargerAllowed}, 16'h0000);
        waitValid();
        chk(alertFlags, 16'h8000);
        chk({15'h0, chargerAllowed}, 16'h0001);
        repeat (3) @(posedge clk);
        #1 chk({15'h0, alertLineLow}, 16'h0001);
        clr();
        for (int i = 0; i < 15; i++)
        begin
            meas(T_CHAN[i], T_VAL[i], T_EXP[i]);
            clr();
        end
        // Set and clear in one cycle: the set wins
        @(posedge clk);
        flagClear <= 16'hFFFF;
        measResult <= '{valid: 1'b1, chan: CH_BATTERY_CURRENT, value: 16'hFE00};
        @(posedge clk);
        flagClear <= 16'h0000;
        measResult.valid <= 1'b0;
        #1 chk(alertFlags, 16'h0010);
        clr();
        meas(CH_BATTERY_VOLTAGE, 16'h0FFF, 16'h0800);
        repeat (5) @(posedge clk);
        #1 chk(alertFlags, 16'h0800);
        pulseDone(16'h4800);
        clr();
        repeat (3) @(posedge clk);
        #1 chk({15'h0, alertLineLow}, 16'h0000);
        wr(8'h0D, 16'h0000);
        meas(CH_BATTERY_VOLTAGE, 16'h0FFF, 16'h0000);
        meas(CH_BATTERY_RESISTANCE, 16'h0201, 16'h0000);
        pulseDone(16'h0000);
        // Dropping the request stops telemetry; the input comparator restarts it
        @(posedge clk);
        forceTelemetryOn <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk({15'h0, telemetryRunning}, 16'h0000);
        @(posedge clk);
        inputAboveBattery <= 1'b1;
        repeat (5) @(posedge clk);
        #1 chk({15'h0, telemetryRunning}, 16'h0001);
        chk({15'h0, chargerAllowed}, 16'h0000);
        waitValid();
        chk({15'h0, chargerAllowed}, 16'h0001);
        give_verdict();
    end

endmodule : telemetry_limit_alert_unit_test
